// ==== mrs_char_rx.sv ====
// Purpose: asynchronous character receiver, 8 data bits lsb first
// Assumes: rxd already synchronous to pclk
// Notes:   samples at mid bit; a short start pulse is dropped as noise
`timescale 1ns/10ps
`default_nettype none
`include "mrs_consts.svh"
module mrs_char_rx (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // line
    input  wire logic rxd,
    // characters
    mrs_rx_if.rx      rx
);
    typedef struct packed {
        mrs_pkg::mrs_rxst_t st;
        logic [16:0]        cnt;
        logic [2:0]         bitn;
        logic [7:0]         sh;
        logic               par;
        logic               perr;
        logic               ferr;
        logic               valid;
    } mrs_rx_state_t;

    mrs_rx_state_t s_q;
    mrs_rx_state_t s_d;

    // bit timing and sampling
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        if (s_q.st != mrs_pkg::RX_IDLE) begin
            s_d.cnt = s_q.cnt - 17'h00001;
        end
        case (s_q.st)
            mrs_pkg::RX_IDLE: begin
                if (!rxd) begin
                    s_d.st = mrs_pkg::RX_START;
                    s_d.cnt = rx.bit_cycles >> 1;
                end
            end
            default: begin
                if (s_q.cnt == 17'h00000) begin
                    s_d.cnt = rx.bit_cycles - 17'h00001;
                    case (s_q.st)
                        mrs_pkg::RX_START: begin
                            s_d.st = rxd ? mrs_pkg::RX_IDLE : mrs_pkg::RX_DATA;
                            s_d.bitn = 3'h0;
                            s_d.par = 1'b0;
                            s_d.perr = 1'b0;
                            s_d.ferr = 1'b0;
                        end
                        mrs_pkg::RX_DATA: begin
                            s_d.sh = {rxd, s_q.sh[7:1]};
                            s_d.par = s_q.par ^ rxd;
                            s_d.bitn = s_q.bitn + 3'h1;
                            if (s_q.bitn == 3'h7) begin
                                s_d.st = (rx.fmt == `MRS_FMT_NONE2) ?
                                    mrs_pkg::RX_STOP1 : mrs_pkg::RX_PAR;
                            end
                        end
                        mrs_pkg::RX_PAR: begin
                            // odd wants an odd total of ones
                            s_d.perr = (rx.fmt == `MRS_FMT_ODD1) ?
                                !(s_q.par ^ rxd) : (s_q.par ^ rxd);
                            s_d.st = mrs_pkg::RX_STOP1;
                        end
                        mrs_pkg::RX_STOP1: begin
                            s_d.ferr = !rxd;
                            if (rx.fmt == `MRS_FMT_NONE2) begin
                                s_d.st = mrs_pkg::RX_STOP2;
                            end else begin
                                s_d.st = mrs_pkg::RX_IDLE;
                                s_d.valid = 1'b1;
                            end
                        end
                        default: begin
                            s_d.ferr = s_q.ferr | !rxd;
                            s_d.st = mrs_pkg::RX_IDLE;
                            s_d.valid = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs to the frame logic
    assign rx.data  = s_q.sh;
    assign rx.valid = s_q.valid;
    assign rx.perr  = s_q.perr;
    assign rx.ferr  = s_q.ferr;
    assign rx.busy  = (s_q.st != mrs_pkg::RX_IDLE);
endmodule
`default_nettype wire

// ==== mrs_consts.svh ====
// Purpose: shared constants of the serial slave link configuration block
// Assumes: included by bare name from every file that needs it
// Notes:   offsets are byte addresses on the register bus
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// register byte offsets
`define MRS_ADDR_STATION  8'h00
`define MRS_ADDR_BAUD     8'h04
`define MRS_ADDR_FORMAT   8'h08
`define MRS_ADDR_LOSS     8'h0C
`define MRS_ADDR_ERRCNT   8'h10
`define MRS_ADDR_STOPMODE 8'h14
`define MRS_ADDR_PROTO    8'h18
`define MRS_ADDR_CMDSRC   8'h1C
`define MRS_ADDR_STATUS   8'h20
`define MRS_ADDR_MASK     8'h24
`define MRS_ADDR_CTRL     8'h28
// reset values
`define MRS_RST_STATION   8'h00
`define MRS_RST_BAUD      9'h0C0
`define MRS_RST_FORMAT    2'h2
`define MRS_RST_LOSS      14'h0000
`define MRS_RST_STOPMODE  2'h0
`define MRS_RST_CMDSRC    14'h270F
// field values
`define MRS_STATION_MAX   8'hF7
`define MRS_FMT_NONE2     2'h0
`define MRS_FMT_ODD1      2'h1
`define MRS_FMT_EVEN1     2'h2
`define MRS_BAUD_48       9'h030
`define MRS_BAUD_96       9'h060
`define MRS_BAUD_192      9'h0C0
`define MRS_BAUD_384      9'h180
`define MRS_LOSS_OFF      14'h270F
`define MRS_CMDSRC_PORT   14'h0002
`define MRS_PROTO_MODBUS  1'h1
// timing
`define MRS_CLK_HZ        250000000
`define MRS_LOSS_TICK_MS  100
`define MRS_CHAR_BITS     11
`define MRS_GAP_HALFCHARS 7
`endif

// ==== mrs_link_config.sv ====
// Purpose: settings, framing and supervision of the front serial port slave
// Assumes: apb master, wait-state-capable; rxd synchronous to pclk
// Notes:   function codes and the reply path sit outside this block
// Function
// - station address zero: never permit any reply frame
// - broadcast to address zero is acted on but never answered
// - replies only with station address 1..247; address resets to zero
// - format 0 none/2 stop, 1 odd/1 stop, 2 even/1 stop
// - character format resets to code 2, even parity one stop
// - loss interval zero faults at once in network command mode (the watchdog here runs only with modbus selected)
// - interval 0.1..999.8 s faults after longer silence than that
// - interval 9999 switches the loss watchdog off
// - error counter reads zero after reset and is read-only
// - stop mode picks coast/decel, fault display, output, restart
// - protocol select 0 computer link (reset), 1 modbus rtu
// - modbus with rate 384 disables the handheld parameter unit
// - operation commands only when command source is 2, or 9999 unfitted
// - rate codes 48/96/192/384 give 4800..38400 bit/s
// - frames bounded by 3.5 character idle gaps
// - no reply on parity, framing or crc error
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "mrs_consts.svh"
module mrs_link_config #(
    parameter int CLK_HZ      = `MRS_CLK_HZ,
    parameter int TICK_CYCLES = CLK_HZ / 1000 * `MRS_LOSS_TICK_MS
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line and drive
    input  wire logic        rxd,
    input  wire logic        motor_stopped,
    // frame results
    output logic             frame_take,
    output logic             cmd_take,
    output logic             reply_permit,
    // drive supervision
    output logic             link_comm_fault,
    output logic             coast_stop,
    output logic             decel_stop,
    output logic             fault_display,
    output logic             fault_output,
    output logic             pu_disable,
    output logic             irq
);
    typedef struct packed {
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
        logic [7:0]         station;
        logic [8:0]         baud;
        logic [1:0]         fmt;
        logic [13:0]        loss;
        logic [15:0]        errcnt;
        logic [1:0]         stopm;
        logic               proto;
        logic [13:0]        cmdsrc;
        logic               netmode;
        logic               optfit;
        logic [2:0]         mask;
        logic [2:0]         stat;
        mrs_pkg::mrs_frame_t fst;
        logic [15:0]        crc;
        logic [7:0]         nbytes;
        logic [7:0]         addr;
        logic               ferr;
        logic [23:0]        gap;
        logic [24:0]        tick;
        logic [13:0]        losscnt;
        logic               fault;
        logic               frame_take;
        logic               cmd_take;
        logic               reply_ok;
        logic               coast;
        logic               decel;
        logic               fdisp;
        logic               fout;
        logic               pudis;
        logic               irq;
    } mrs_state_t;

    mrs_state_t s_q;
    mrs_state_t s_d;
    mrs_rx_if   rxi ();

    // rate code to clock cycles per bit
    function automatic logic [16:0] bit_cycles(input logic [8:0] code);
        bit_cycles = 17'(CLK_HZ / (int'(code) * 100));
    endfunction

    // one byte step of the reflected crc-16, init all ones
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
        end
        crc_step = r;
    endfunction

    // character receiver
    mrs_char_rx i_mrs_char_rx (
        .pclk    (pclk),
        .presetn (presetn),
        .rxd     (rxd),
        .rx      (rxi)
    );
    assign rxi.bit_cycles = bit_cycles(s_q.baud);
    assign rxi.fmt        = s_q.fmt;

    logic [23:0] gap_lim;
    logic        modbus;
    logic        wd_active;
    logic        net_ok;
    logic        own_hit;
    logic        good;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [2:0]  ev;
    logic [2:0]  rdclr;

    // frame gap, mode and command source decode
    assign gap_lim   = 24'(rxi.bit_cycles * `MRS_CHAR_BITS
                       * `MRS_GAP_HALFCHARS / 2);
    assign modbus    = (s_q.proto == `MRS_PROTO_MODBUS);
    assign net_ok    = (s_q.cmdsrc == `MRS_CMDSRC_PORT) ||
                       ((s_q.cmdsrc == `MRS_LOSS_OFF) && !s_q.optfit);
    assign wd_active = modbus && s_q.netmode &&
                       (s_q.loss != `MRS_LOSS_OFF);
    assign good      = !s_q.ferr && (s_q.nbytes >= 8'h04) &&
                       (s_q.crc == 16'h0000);
    assign own_hit   = (s_q.addr == s_q.station) &&
                       (s_q.station != 8'h00) &&
                       (s_q.station <= `MRS_STATION_MAX);
    assign acc       = psel && penable && s_q.pready;
    assign wr        = acc && pwrite;
    assign rd        = acc && !pwrite;

    // next state
    always_comb begin
        s_d = s_q;
        ev = 3'h0;
        rdclr = 3'h0;
        s_d.frame_take = 1'b0;
        s_d.cmd_take = 1'b0;
        s_d.reply_ok = 1'b0;
        // apb: one wait cycle so read data comes from a flop
        s_d.pready = psel && penable && !s_q.pready;
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = 1'b0;
            case (paddr)
                `MRS_ADDR_STATION:  s_d.prdata = {24'h0, s_q.station};
                `MRS_ADDR_BAUD:     s_d.prdata = {23'h0, s_q.baud};
                `MRS_ADDR_FORMAT:   s_d.prdata = {30'h0, s_q.fmt};
                `MRS_ADDR_LOSS:     s_d.prdata = {18'h0, s_q.loss};
                `MRS_ADDR_ERRCNT:   s_d.prdata = {16'h0, s_q.errcnt};
                `MRS_ADDR_STOPMODE: s_d.prdata = {30'h0, s_q.stopm};
                `MRS_ADDR_PROTO:    s_d.prdata = {31'h0, s_q.proto};
                `MRS_ADDR_CMDSRC:   s_d.prdata = {18'h0, s_q.cmdsrc};
                `MRS_ADDR_STATUS:   s_d.prdata = {29'h0, s_q.stat};
                `MRS_ADDR_MASK:     s_d.prdata = {29'h0, s_q.mask};
                `MRS_ADDR_CTRL: begin
                    s_d.prdata = {28'h0, s_q.fault, 1'b0, s_q.optfit,
                                  s_q.netmode};
                end
                default: begin
                    s_d.prdata = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // register writes; out-of-range station, rate, format and loss values are ignored
        if (wr) begin
            case (paddr)
                `MRS_ADDR_STATION: begin
                    if (pwdata[7:0] <= `MRS_STATION_MAX) begin
                        s_d.station = pwdata[7:0];
                    end
                end
                `MRS_ADDR_BAUD: begin
                    if (pwdata[8:0] == `MRS_BAUD_48 ||
                        pwdata[8:0] == `MRS_BAUD_96 ||
                        pwdata[8:0] == `MRS_BAUD_192 ||
                        pwdata[8:0] == `MRS_BAUD_384) begin
                        s_d.baud = pwdata[8:0];
                    end
                end
                `MRS_ADDR_FORMAT: begin
                    if (pwdata[1:0] <= `MRS_FMT_EVEN1) begin
                        s_d.fmt = pwdata[1:0];
                    end
                end
                `MRS_ADDR_LOSS: begin
                    if (pwdata[13:0] <= `MRS_LOSS_OFF) begin
                        s_d.loss = pwdata[13:0];
                    end
                end
                `MRS_ADDR_STOPMODE: s_d.stopm = pwdata[1:0];
                `MRS_ADDR_PROTO:    s_d.proto = pwdata[0];
                `MRS_ADDR_CMDSRC:   s_d.cmdsrc = pwdata[13:0];
                `MRS_ADDR_MASK:     s_d.mask = pwdata[2:0];
                `MRS_ADDR_CTRL: begin
                    s_d.netmode = pwdata[0];
                    s_d.optfit = pwdata[1];
                end
                default: ;
            endcase
        end
        // error counter has no write path at all
        if (rd && paddr == `MRS_ADDR_STATUS) begin
            rdclr = 3'h7;
        end
        // idle gap since the end of the last character
        if (rxi.busy || rxi.valid) begin
            s_d.gap = 24'h0;
        end else if (s_q.gap < gap_lim) begin
            s_d.gap = s_q.gap + 24'h1;
        end
        // frame tracking; partial frame after reset is skipped
        case (s_q.fst)
            mrs_pkg::FR_SYNC: begin
                if (s_q.gap >= gap_lim && !rxi.busy) begin
                    s_d.fst = mrs_pkg::FR_IDLE;
                end
            end
            mrs_pkg::FR_IDLE: begin
                if (rxi.valid) begin
                    s_d.fst = mrs_pkg::FR_RECV;
                    s_d.addr = rxi.data;
                    s_d.nbytes = 8'h01;
                    s_d.ferr = rxi.perr || rxi.ferr;
                    s_d.crc = crc_step(16'hFFFF, rxi.data);
                end
            end
            mrs_pkg::FR_RECV: begin
                if (rxi.valid) begin
                    if (s_q.nbytes != 8'hFF) begin
                        s_d.nbytes = s_q.nbytes + 8'h01;
                    end
                    s_d.ferr = s_q.ferr || rxi.perr || rxi.ferr;
                    s_d.crc = crc_step(s_q.crc, rxi.data);
                end else if (s_q.gap >= gap_lim && !rxi.busy) begin
                    s_d.fst = mrs_pkg::FR_IDLE;
                    if (modbus && good) begin
                        if (s_q.addr == 8'h00 || own_hit) begin
                            s_d.frame_take = 1'b1;
                            s_d.cmd_take = net_ok;
                            ev[0] = 1'b1;
                        end
                        // broadcast and station zero stay silent
                        s_d.reply_ok = own_hit;
                    end else if (modbus) begin
                        ev[1] = 1'b1;
                        if (s_q.errcnt != 16'hFFFF) begin
                            s_d.errcnt = s_q.errcnt + 16'h1;
                        end
                    end
                end
            end
            default: s_d.fst = mrs_pkg::FR_SYNC;
        endcase
        // signal-loss watchdog in tenths of a second
        if (!wd_active || (s_d.reply_ok)) begin
            s_d.tick = 25'h0;
            s_d.losscnt = 14'h0;
        end else if (s_q.tick >= 25'(TICK_CYCLES - 1)) begin
            s_d.tick = 25'h0;
            if (s_q.losscnt != 14'h3FFF) begin
                s_d.losscnt = s_q.losscnt + 14'h1;
            end
        end else begin
            s_d.tick = s_q.tick + 25'h1;
        end
        if (wd_active && !s_q.fault &&
            (s_q.loss == 14'h0 || s_q.losscnt > s_q.loss)) begin
            s_d.fault = 1'b1;
            ev[2] = 1'b1;
        end else if (s_q.fault && wr && paddr == `MRS_ADDR_CTRL &&
                     pwdata[2]) begin
            s_d.fault = 1'b0;
        end else if (s_q.fault && s_q.stopm == 2'h2 && s_d.reply_ok &&
                     s_q.loss != 14'h0) begin
            s_d.fault = 1'b0;
        end
        // stop action: 0/3 coast and trip, 1 decel then trip, 2 restartable
        s_d.coast = s_q.fault && (s_q.stopm == 2'h0 || s_q.stopm == 2'h3);
        s_d.decel = s_q.fault && (s_q.stopm == 2'h1 || s_q.stopm == 2'h2);
        s_d.fdisp = s_q.fault && (s_d.coast || motor_stopped);
        s_d.fout  = s_q.fault && (s_d.coast ||
                    (s_q.stopm == 2'h1 && motor_stopped));
        s_d.pudis = modbus && (s_q.baud == `MRS_BAUD_384);
        // sticky status: a new event beats the read clear
        s_d.stat = (s_q.stat & ~rdclr) | ev;
        s_d.irq = |(s_q.stat & s_q.mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.station <= `MRS_RST_STATION;
            s_q.baud <= `MRS_RST_BAUD;
            s_q.fmt <= `MRS_RST_FORMAT;
            s_q.loss <= `MRS_RST_LOSS;
            s_q.stopm <= `MRS_RST_STOPMODE;
            s_q.cmdsrc <= `MRS_RST_CMDSRC;
            s_q.errcnt <= 16'h0;
            s_q.fst <= mrs_pkg::FR_SYNC;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign prdata          = s_q.prdata;
    assign pready          = s_q.pready;
    assign pslverr         = s_q.pslverr;
    assign frame_take      = s_q.frame_take;
    assign cmd_take        = s_q.cmd_take;
    assign reply_permit    = s_q.reply_ok;
    assign link_comm_fault = s_q.fault;
    assign coast_stop      = s_q.coast;
    assign decel_stop      = s_q.decel;
    assign fault_display   = s_q.fdisp;
    assign fault_output    = s_q.fout;
    assign pu_disable      = s_q.pudis;
    assign irq             = s_q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_NO_REPLY_STN0: assert property (reply_permit |-> s_q.station != 8'h00)
        else $error("reply permitted with station zero");
    AST_BCAST_SILENT: assert property (reply_permit |-> s_q.addr != 8'h00)
        else $error("reply permitted to broadcast");
    AST_STN_RANGE: assert property (reply_permit |-> frame_take &&
        s_q.station <= `MRS_STATION_MAX)
        else $error("reply outside station range");
    AST_FMT_RESET: assert property ($past(!presetn) |-> s_q.fmt == 2'h2)
        else $error("format not even parity after reset");
    AST_LOSS_ZERO: assert property (wd_active && s_q.loss == 14'h0
        |-> ##[0:1] link_comm_fault)
        else $error("zero interval did not fault");
    AST_LOSS_OFF: assert property ($rose(link_comm_fault)
        |-> $past(s_q.loss) != `MRS_LOSS_OFF)
        else $error("fault with watchdog off");
    AST_ERR_STEP: assert property (s_q.errcnt != $past(s_q.errcnt)
        |-> s_q.errcnt == $past(s_q.errcnt) + 16'h1 && $past(s_q.fst)
        == mrs_pkg::FR_RECV)
        else $error("error counter moved wrongly");
    AST_PU_DIS: assert property (pu_disable == $past(s_q.proto &&
        s_q.baud == `MRS_BAUD_384))
        else $error("parameter unit disable wrong");
    AST_CMD_SRC: assert property (cmd_take |-> $past(net_ok) && frame_take)
        else $error("command taken from wrong source");
    AST_MODE2_NOOUT: assert property ($past(s_q.stopm) == 2'h2
        |-> !fault_output)
        else $error("fault output in mode two");
    AST_BAD_NOREPLY: assert property ($rose(s_q.stat[1]) |-> !reply_permit)
        else $error("reply after bad frame");

    COV_OWN_REPLY: cover property (reply_permit);
    COV_BCAST: cover property (frame_take && !reply_permit);
    COV_ERR_FRAME: cover property ($rose(s_q.stat[1]));
    COV_FAULT: cover property ($rose(link_comm_fault));
endmodule
`default_nettype wire

// ==== mrs_link_config_tb.sv ====
// Purpose: self-checking bench of the link configuration block
// Assumes: CLK_HZ lowered so one bit is 100 cycles at rate 384
// Notes:   frame results are counted, not sampled
`timescale 1ns/10ps
`default_nettype none
`include "mrs_consts.svh"
module mrs_link_config_tb;
    logic        pclk, presetn, psel, penable, pwrite, rxd, err, irq;
    logic        pready, pslverr, frame_take, cmd_take, reply_permit;
    logic        link_comm_fault, coast_stop, decel_stop, fault_display;
    logic        fault_output, pu_disable, motor_stopped;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  ntak = 8'h00, nrep = 8'h00, ncmd = 8'h00;
    int          failures, cmp_count;
    // stop action outputs gathered for one compare
    wire  [4:0]  stp = {link_comm_fault, coast_stop, fault_output,
                        fault_display, decel_stop};
    mrs_link_config #(.CLK_HZ(3840000), .TICK_CYCLES(20)) i_mrs_link_config (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxd, .motor_stopped, .frame_take, .cmd_take,
        .reply_permit, .link_comm_fault, .coast_stop, .decel_stop,
        .fault_display, .fault_output, .pu_disable, .irq);
    mrs_master_model #(.BIT(100)) i_mrs_master_model (.pclk, .rxd);
    // result pulses last one cycle, so count them
    always @(posedge pclk) begin
        ntak <= ntak + {7'h00, frame_take};
        nrep <= nrep + {7'h00, reply_permit};
        ncmd <= ncmd + {7'h00, cmd_take};
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic frm(input logic [7:0] a, input logic b, input logic [23:0] e);
        i_mrs_master_model.send(a, b);
        chk({8'h00, ncmd, nrep, ntak}, {8'h00, e});
        $display("frame test done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // hang guard, well past five frames
    initial begin
        repeat (80000) @(posedge pclk);
        failures++;
        finish_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, motor_stopped} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`MRS_ADDR_STATION, 32'h0);
        rd(`MRS_ADDR_FORMAT, 32'h2);
        rd(`MRS_ADDR_BAUD, 32'hC0);
        rd(`MRS_ADDR_PROTO, 32'h0);
        apb(1'b1, `MRS_ADDR_ERRCNT, 32'h5);
        rd(`MRS_ADDR_ERRCNT, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        // code 3 is refused, the run ends on code 2
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `MRS_ADDR_FORMAT, 32'((i + 3) % 4));
            rd(`MRS_ADDR_FORMAT, 32'(i == 0 ? 2 : (i + 3) % 4));
        end
        apb(1'b1, `MRS_ADDR_BAUD, 32'h180);
        apb(1'b1, `MRS_ADDR_PROTO, 32'h1);
        apb(1'b1, `MRS_ADDR_MASK, 32'h3);
        chk({31'h0, pu_disable}, 32'h1);
        frm(8'h05, 1'b0, 24'h000000);
        apb(1'b1, `MRS_ADDR_STATION, 32'h5);
        frm(8'h05, 1'b0, 24'h010101);
        frm(8'h00, 1'b0, 24'h020102);
        frm(8'h05, 1'b1, 24'h020102);
        rd(`MRS_ADDR_ERRCNT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd(`MRS_ADDR_STATUS, 32'h3);
        apb(1'b1, `MRS_ADDR_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        chk({27'h0, stp}, 32'h1E);
        apb(1'b1, `MRS_ADDR_STOPMODE, 32'h1);
        repeat (2) @(posedge pclk);
        chk({27'h0, stp}, 32'h11);
        motor_stopped <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({27'h0, stp}, 32'h17);
        apb(1'b1, `MRS_ADDR_STOPMODE, 32'h2);
        repeat (2) @(posedge pclk);
        chk({27'h0, stp}, 32'h13);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `MRS_ADDR_LOSS, 32'h270F);
        apb(1'b1, `MRS_ADDR_CTRL, 32'h5);
        repeat (100) @(posedge pclk);
        chk({31'h0, link_comm_fault}, 32'h0);
        // two ticks of 20 cycles allowed, fault after the third
        apb(1'b1, `MRS_ADDR_LOSS, 32'h2);
        repeat (50) @(posedge pclk);
        chk({31'h0, link_comm_fault}, 32'h0);
        repeat (20) @(posedge pclk);
        chk({31'h0, link_comm_fault}, 32'h1);
        // option fitted blocks commands; own frame restarts mode 2
        apb(1'b1, `MRS_ADDR_LOSS, 32'hC8);
        apb(1'b1, `MRS_ADDR_CTRL, 32'h3);
        apb(1'b1, `MRS_ADDR_FORMAT, 32'h1);
        i_mrs_master_model.odd = 1'b1;
        frm(8'h05, 1'b0, 24'h020203);
        chk({31'h0, link_comm_fault}, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire

// ==== mrs_master_model.sv ====
// Purpose: serial master model feeding the slave line
// Assumes: even parity unless odd is set, one stop bit, BIT cycles per bit
// Notes:   line idles high; a frame is addr, func, crc low, crc high
`timescale 1ns/10ps
`default_nettype none
module mrs_master_model #(
    parameter int BIT = 100
) (
    // clock and line
    input  wire logic pclk,
    output logic      rxd
);
    logic odd = 1'b0; // set by the bench for odd-parity frames
    initial rxd = 1'b1;
    // start, data lsb first, parity, stop
    task automatic put(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b ^ odd, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask
    // bad spoils the crc low byte; idle gap on both sides
    task automatic send(input logic [7:0] a, input logic bad);
        logic [15:0] c;
        c = 16'hFFFF ^ {8'h00, a};
        for (int j = 0; j < 16; j++) begin
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
            if (j == 7) c = c ^ 16'h0003;
        end
        repeat (BIT * 45) @(posedge pclk);
        put(a);
        put(8'h03);
        put(c[7:0] ^ {7'h00, bad});
        put(c[15:8]);
        rxd <= 1'b1;
        repeat (BIT * 45) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ==== mrs_pkg.sv ====
// Purpose: types of the serial slave link configuration block
// Assumes: nothing
// Notes:   constants live in mrs_consts.svh
package mrs_pkg;
    typedef enum logic [1:0] {FR_SYNC, FR_IDLE, FR_RECV} mrs_frame_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
    } mrs_rxst_t;
endpackage

// ==== mrs_rx_if.sv ====
// Purpose: character path between receiver and frame logic
// Assumes: one clock domain
// Notes:   valid is a one-cycle pulse, errors qualify it
`timescale 1ns/10ps
`default_nettype none
interface mrs_rx_if;
    logic [16:0] bit_cycles;
    logic [1:0]  fmt;
    logic [7:0]  data;
    logic        valid;
    logic        perr;
    logic        ferr;
    logic        busy;
    modport rx   (input bit_cycles, fmt, output data, valid, perr, ferr, busy);
    modport core (output bit_cycles, fmt, input data, valid, perr, ferr, busy);
endinterface
`default_nettype wire
